// ==== spq_port.sv ====
// serial peripheral port with register bus, transmit buffer and quirks
// What this block does
// - single soft reset lets clock lead select
// - odd divider above one, idle high, phase 0: extra pulse
// - hold, divider one, idle gap: word repeats
// - fixed hold final flag: select rises drained
// - dma size follows select zero word length
// - divider one, odd length: extra clock pulse
// - target mode ignores the disable command
// - soft reset keeps enable, flags stay low
// - long held idle: switch select without delay
// - slow then divider-one select, idle high, phase 0: extra pulse
// - all selects divider one: no slow-then-fast pulse
`timescale 1ns/1ps
module spq_port import spq_pkg::*; #(
   parameter int unsigned FIFO_DEPTH = 4
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // controller-mode pins
   output logic serial_clock_pin,
   output logic mosi_o,
   input wire logic miso_i,
   output logic [NUM_SEL-1:0] peripheral_select_lines_n,
   // target-mode pins
   input wire logic tgt_sclk_i,
   input wire logic tgt_sel_n_i,
   input wire logic tgt_mosi_i,
   // dma channel handshake
   output logic dma_tx_req,
   output logic dma_half
);
   if (FIFO_DEPTH != 4) begin : g_bad
      $error("spq_port: buffer depth must be 4");
   end
   localparam logic [NUM_SEL-1:0] SEL_ONE = 4'h1;
   localparam logic [NUM_SEL-1:0] SEL_NONE = 4'hf;

   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic aw_hold_r, w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic enable_r, armed_r, half_reset_r, last_soft_reset_command_r;
   logic [31:0] mode_r;
   logic [31:0] sel_cfg_r [NUM_SEL];
   logic [NUM_SEL-1:0] div_one;
   logic [WORD_W-1:0] rx_data_r;
   logic rx_ready_r;
   spq_state_e state_r;
   logic sclk_r, mosi_r, final_r, dup_r, xpulse_r;
   logic [NUM_SEL-1:0] sel_n_r;
   logic [WORD_W-1:0] shift_r, rxsh_r, trx_r;
   logic [5:0] edge_cnt_r;
   logic [1:0] cur_sel_r;
   logic [7:0] cur_div_r, last_div_r, cur_scdly_r, cur_ctdly_r, dly_cnt_r;
   logic cur_idle_r, cur_phinv_r, cur_hold_r;
   logic [3:0] cur_bits_r;
   logic [8:0] idle_cnt_r;
   logic tgt_sclk_prev_r;
   logic [4:0] tgt_cnt_r;
   logic dma_tx_req_r, dma_half_r;

   logic wr_go, wr_fire, is_tx, wr_map, soft_reset_command_p;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [31:0] fifo_word;
   logic run, tick, load, r04_hit, held, same_sel, idle_over;
   logic frame_end, tgt_done, tx_space, drained;
   logic [1:0] new_sel;
   logic [31:0] new_cfg;
   logic [4:0] nbits;
   logic [WORD_W-1:0] rx_word;
   logic [31:0] rd_data;
   logic rd_map;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) res[8*i +: 8] = nw[8*i +: 8];
      end
      return res;
   endfunction

   // ---------------- register bus ----------------
   assign is_tx = (awaddr_r == OFF_TXDATA);
   assign wr_map = (awaddr_r == OFF_CTRL) || (awaddr_r == OFF_MODE) ||
      is_tx || (awaddr_r == OFF_STATUS) || (awaddr_r == OFF_RXDATA) ||
      (awaddr_r[7:4] == OFF_SEL0[7:4] && awaddr_r[1:0] == 2'b00);
   assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
   // a transmit word waits while the buffer is full
   assign wr_fire = wr_go && (!is_tx || fifo_in_ready);
   // taken from wr_go so the buffer flush does not loop back to itself
   assign soft_reset_command_p = wr_go && awaddr_r == OFF_CTRL &&
      wstrb_r[0] && wdata_r[CTRL_SOFT_RESET];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (awvalid && awready_r) begin
            aw_hold_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= awaddr;
         end
         if (wvalid && wready_r) begin
            w_hold_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_map = 1'b1;
      if (araddr == OFF_CTRL || araddr == OFF_TXDATA) begin
         rd_data = 32'h0000_0000;
      end else if (araddr == OFF_MODE) begin
         rd_data = mode_r;
      end else if (araddr == OFF_STATUS) begin
         rd_data[ST_RX_READY] = rx_ready_r;
         rd_data[ST_TX_SPACE] = tx_space;
         rd_data[ST_DRAINED] = drained;
         rd_data[ST_ENABLED] = enable_r;
         rd_data[ST_DMA_HALF] = dma_half_r;
      end else if (araddr == OFF_RXDATA) begin
         rd_data = {16'h0000, rx_data_r};
      end else if (araddr[7:4] == OFF_SEL0[7:4] && araddr[1:0] == 2'b00) begin
         rd_data = sel_cfg_r[araddr[3:2]];
      end else begin
         rd_map = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_data;
         rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // ---------------- control and configuration ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_r <= 1'b0;
         armed_r <= 1'b0;
         half_reset_r <= 1'b0;
         last_soft_reset_command_r <= 1'b0;
      end else if (wr_fire) begin
         last_soft_reset_command_r <= soft_reset_command_p;
         if (soft_reset_command_p) begin
            half_reset_r <= !last_soft_reset_command_r;
            armed_r <= 1'b0;
         end else if (awaddr_r == OFF_CTRL && wstrb_r[0]) begin
            if (wdata_r[CTRL_DISABLE] && mode_r[MODE_CONTROLLER]) begin
               enable_r <= 1'b0;
               armed_r <= 1'b0;
            end else if (wdata_r[CTRL_ENABLE] && !enable_r) begin
               enable_r <= 1'b1;
               armed_r <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || soft_reset_command_p) begin
         mode_r <= MODE_RST;
      end else if (wr_fire && awaddr_r == OFF_MODE) begin
         mode_r <= merge(mode_r, wdata_r, wstrb_r);
      end
   end

   for (genvar g = 0; g < NUM_SEL; g++) begin : g_sel
      assign div_one[g] = sel_cfg_r[g][CFG_DIV_LSB +: 8] == DIV_ONE;
      always_ff @(posedge aclk) begin
         if (!aresetn || soft_reset_command_p) begin
            sel_cfg_r[g] <= CFG_RST;
         end else if (wr_fire && awaddr_r[7:4] == OFF_SEL0[7:4] &&
                      awaddr_r[3:2] == 2'(g)) begin
            sel_cfg_r[g] <= merge(sel_cfg_r[g], wdata_r, wstrb_r);
         end
      end
   end

   // ---------------- transmit buffer ----------------
   spq_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .flush(soft_reset_command_p),
      .in_valid(wr_go && is_tx),
      .in_ready(fifo_in_ready),
      .in_data(wdata_r),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_word)
   );

   spq_clkdiv #(.DIV_W(8)) u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(state_r == ST_SHIFT || state_r == ST_EXTRA),
      .div(cur_div_r),
      .tick(tick)
   );

   // ---------------- controller engine ----------------
   assign run = enable_r && mode_r[MODE_CONTROLLER];
   assign new_sel = mode_r[MODE_VARIABLE] ?
      fifo_word[TX_SEL_LSB +: 2] : mode_r[MODE_SEL_LSB +: 2];
   assign new_cfg = sel_cfg_r[new_sel];
   assign held = (sel_n_r != SEL_NONE);
   assign same_sel = held && (new_sel == cur_sel_r);
   assign idle_over = idle_cnt_r > ({1'b0, cur_ctdly_r} + {1'b0, cur_scdly_r});
   assign load = run && state_r == ST_IDLE && fifo_out_valid;
   assign r04_hit = !dup_r && new_cfg[CFG_HOLD] && same_sel &&
      new_cfg[CFG_DIV_LSB +: 8] == DIV_ONE && idle_cnt_r != 9'h000;
   assign fifo_pop = load && !r04_hit;
   assign nbits = {1'b0, BITS_MIN} + {1'b0, cur_bits_r};
   assign frame_end = tick && ((state_r == ST_SHIFT && !xpulse_r &&
      edge_cnt_r == {nbits, 1'b0} - 6'h01) ||
      (state_r == ST_EXTRA && edge_cnt_r[0]));
   assign rx_word = (state_r == ST_SHIFT && !cur_phinv_r) ?
      {rxsh_r[WORD_W-2:0], miso_i} : rxsh_r;
   assign drained = armed_r && !fifo_out_valid && state_r == ST_IDLE;
   assign tx_space = armed_r && fifo_in_ready && !dup_r;

   always_ff @(posedge aclk) begin
      if (!aresetn || soft_reset_command_p || !run) begin
         state_r <= ST_IDLE;
         sel_n_r <= SEL_NONE;
         sclk_r <= 1'b0;
         mosi_r <= 1'b0;
         dup_r <= 1'b0;
         final_r <= 1'b0;
         xpulse_r <= 1'b0;
         idle_cnt_r <= 9'h000;
         edge_cnt_r <= 6'h00;
         dly_cnt_r <= 8'h00;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               sclk_r <= cur_idle_r;
               if (held && idle_cnt_r != 9'h1ff) begin
                  idle_cnt_r <= idle_cnt_r + 1'b1;
               end
               if (final_r && !fifo_out_valid && held) begin
                  sel_n_r <= SEL_NONE;
                  final_r <= 1'b0;
               end
               if (load) begin
                  dup_r <= r04_hit;
                  // park the clock at its new idle level before select
                  sclk_r <= new_cfg[CFG_IDLE];
                  final_r <= fifo_word[TX_FINAL];
                  idle_cnt_r <= 9'h000;
                  edge_cnt_r <= 6'h00;
                  dly_cnt_r <= new_cfg[CFG_SCDLY_LSB +: 8];
                  shift_r <= fifo_word[WORD_W-1:0] <<
                     (4'h8 - new_cfg[CFG_BITS_LSB +: 4]);
                  mosi_r <= new_cfg[CFG_PHINV] &&
                     fifo_word[7 + new_cfg[CFG_BITS_LSB +: 4]];
                  xpulse_r <= (new_cfg[CFG_IDLE] && !new_cfg[CFG_PHINV] &&
                     new_cfg[CFG_DIV_LSB] &&
                     new_cfg[CFG_DIV_LSB +: 8] != DIV_ONE) ||
                     (new_cfg[CFG_DIV_LSB +: 8] == DIV_ONE &&
                     new_cfg[CFG_BITS_LSB]) ||
                     (new_cfg[CFG_IDLE] && !new_cfg[CFG_PHINV] &&
                     new_cfg[CFG_DIV_LSB +: 8] == DIV_ONE &&
                     last_div_r != DIV_ONE && !(&div_one));
                  if (same_sel) begin
                     state_r <= ST_SHIFT;
                  end else if (held && cur_hold_r && idle_over) begin
                     sel_n_r <= ~(SEL_ONE << new_sel);
                     state_r <= ST_SHIFT;
                  end else begin
                     sel_n_r <= SEL_NONE;
                     state_r <= ST_SETUP;
                  end
               end
            end
            ST_SETUP: begin
               if (half_reset_r) sclk_r <= !cur_idle_r;
               if (dly_cnt_r == 8'h00) begin
                  sel_n_r <= ~(SEL_ONE << cur_sel_r);
                  sclk_r <= cur_idle_r;
                  state_r <= ST_SHIFT;
               end else begin
                  dly_cnt_r <= dly_cnt_r - 1'b1;
               end
            end
            ST_SHIFT: begin
               if (tick) begin
                  sclk_r <= !sclk_r;
                  edge_cnt_r <= edge_cnt_r + 1'b1;
                  if (edge_cnt_r[0] == cur_phinv_r) begin
                     mosi_r <= cur_phinv_r ? shift_r[WORD_W-2] :
                        shift_r[WORD_W-1];
                     shift_r <= {shift_r[WORD_W-2:0], 1'b0};
                  end
                  if (edge_cnt_r == {nbits, 1'b0} - 6'h01 && xpulse_r) begin
                     edge_cnt_r <= 6'h00;
                     state_r <= ST_EXTRA;
                  end
               end
            end
            ST_EXTRA: begin
               if (tick) begin
                  sclk_r <= !sclk_r;
                  edge_cnt_r <= edge_cnt_r + 1'b1;
               end
            end
            ST_GAP: begin
               if (dly_cnt_r == 8'h00) begin
                  state_r <= ST_IDLE;
               end else begin
                  dly_cnt_r <= dly_cnt_r - 1'b1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
         if (frame_end) begin
            state_r <= ST_GAP;
            dly_cnt_r <= cur_ctdly_r;
            if (!cur_hold_r || (final_r && mode_r[MODE_VARIABLE])) begin
               sel_n_r <= SEL_NONE;
               final_r <= 1'b0;
            end
         end
      end
   end

   // received bits and the transfer's latched configuration
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_reset_command_p) begin
         rxsh_r <= '0;
         cur_sel_r <= 2'b00;
         cur_div_r <= DIV_ONE;
         last_div_r <= DIV_ONE;
         cur_scdly_r <= 8'h00;
         cur_ctdly_r <= 8'h00;
         cur_idle_r <= 1'b0;
         cur_phinv_r <= 1'b0;
         cur_hold_r <= 1'b0;
         cur_bits_r <= 4'h0;
      end else if (load) begin
         rxsh_r <= '0;
         cur_sel_r <= new_sel;
         last_div_r <= cur_div_r;
         cur_div_r <= new_cfg[CFG_DIV_LSB +: 8];
         cur_scdly_r <= new_cfg[CFG_SCDLY_LSB +: 8];
         cur_ctdly_r <= new_cfg[CFG_CTDLY_LSB +: 8];
         cur_idle_r <= new_cfg[CFG_IDLE];
         cur_phinv_r <= new_cfg[CFG_PHINV];
         cur_hold_r <= new_cfg[CFG_HOLD];
         cur_bits_r <= new_cfg[CFG_BITS_LSB +: 4];
      end else if (state_r == ST_SHIFT && tick &&
                   edge_cnt_r[0] != cur_phinv_r) begin
         rxsh_r <= {rxsh_r[WORD_W-2:0], miso_i};
      end
   end

   // ---------------- target receiver ----------------
   // a disable command written in target mode never reaches this path
   assign tgt_done = enable_r && !mode_r[MODE_CONTROLLER] && !tgt_sel_n_i &&
      tgt_sclk_i && !tgt_sclk_prev_r &&
      tgt_cnt_r == BITS_MIN + sel_cfg_r[0][CFG_BITS_LSB +: 4] - 1'b1;
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_reset_command_p) begin
         tgt_sclk_prev_r <= 1'b0;
         tgt_cnt_r <= 5'h00;
         trx_r <= '0;
      end else begin
         tgt_sclk_prev_r <= tgt_sclk_i;
         if (tgt_sel_n_i || tgt_done) begin
            tgt_cnt_r <= 5'h00;
         end else if (tgt_sclk_i && !tgt_sclk_prev_r) begin
            tgt_cnt_r <= tgt_cnt_r + 1'b1;
            trx_r <= {trx_r[WORD_W-2:0], tgt_mosi_i};
         end
      end
   end

   // receive data: a new word wins over a clearing read
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_reset_command_p) begin
         rx_data_r <= '0;
         rx_ready_r <= 1'b0;
      end else if (frame_end || tgt_done) begin
         rx_data_r <= frame_end ? rx_word : {trx_r[WORD_W-2:0], tgt_mosi_i};
         rx_ready_r <= 1'b1;
      end else if (arvalid && arready_r && araddr == OFF_RXDATA) begin
         rx_ready_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_tx_req_r <= 1'b0;
         dma_half_r <= 1'b0;
      end else begin
         dma_tx_req_r <= tx_space;
         dma_half_r <= sel_cfg_r[0][CFG_BITS_LSB +: 4] != 4'h0;
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign serial_clock_pin = sclk_r;
   assign mosi_o = mosi_r;
   assign peripheral_select_lines_n = sel_n_r;
   assign dma_tx_req = dma_tx_req_r;
   assign dma_half = dma_half_r;
endmodule

// ==== spq_pkg.sv ====
// shared constants and types of the serial peripheral port
package spq_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned NUM_SEL = 4;
   localparam int unsigned WORD_W = 16;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_RXDATA = 8'h0c;
   localparam logic [7:0] OFF_TXDATA = 8'h10;
   localparam logic [7:0] OFF_SEL0 = 8'h20;
   // command register bits
   localparam int unsigned CTRL_ENABLE = 0;
   localparam int unsigned CTRL_DISABLE = 1;
   localparam int unsigned CTRL_SOFT_RESET = 7;
   // mode register fields
   localparam int unsigned MODE_CONTROLLER = 0;
   localparam int unsigned MODE_VARIABLE = 1;
   localparam int unsigned MODE_SEL_LSB = 16;
   // transmit word fields
   localparam int unsigned TX_SEL_LSB = 16;
   localparam int unsigned TX_FINAL = 24;
   // status bits
   localparam int unsigned ST_RX_READY = 0;
   localparam int unsigned ST_TX_SPACE = 1;
   localparam int unsigned ST_DRAINED = 9;
   localparam int unsigned ST_ENABLED = 16;
   localparam int unsigned ST_DMA_HALF = 24;
   // select configuration fields
   localparam int unsigned CFG_IDLE = 0;
   localparam int unsigned CFG_PHINV = 1;
   localparam int unsigned CFG_HOLD = 3;
   localparam int unsigned CFG_BITS_LSB = 4;
   localparam int unsigned CFG_DIV_LSB = 8;
   localparam int unsigned CFG_SCDLY_LSB = 16;
   localparam int unsigned CFG_CTDLY_LSB = 24;
   // reset values and other fixed constants
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_RST = 32'h0000_0100;
   localparam logic [7:0] DIV_ONE = 8'h01;
   localparam logic [3:0] BITS_MIN = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_SHIFT = 3'b010,
      ST_EXTRA = 3'b011,
      ST_GAP = 3'b100
   } spq_state_e;
endpackage

// ==== spq_fifo.sv ====
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module spq_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 4
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("spq_fifo: depth must be a power of two of at least 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r, rd_ptr_r;
   logic [AW:0] count_r;
   logic push, pop;
   assign in_ready = (count_r != (AW+1)'(DEPTH)) && !flush;
   assign out_valid = (count_r != '0) && !flush;
   assign out_data = mem[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==== spq_clkdiv.sv ====
// serial clock divider producing one-cycle edge enables
`timescale 1ns/1ps
module spq_clkdiv #(
   parameter int unsigned DIV_W = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic run,
   input wire logic [DIV_W-1:0] div,
   // one pulse per serial clock edge
   output logic tick
);
   if (DIV_W < 1) begin : g_bad
      $error("spq_clkdiv: width must be at least 1");
   end
   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] last;
   // a divider of zero behaves as one
   assign last = (div == '0) ? '0 : div - 1'b1;
   assign tick = run && (cnt_r == last);
   always_ff @(posedge aclk) begin
      if (!aresetn || !run || tick) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule

// ==== spq_port_chk.sv ====
// bus and pin assertions of the serial peripheral port
`timescale 1ns/1ps
module spq_port_chk import spq_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   // selects
   input wire logic [NUM_SEL-1:0] peripheral_select_lines_n
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence wr_take;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence bad_wr;
      wr_take ##0 awaddr >= 8'h30;
   endsequence
   a_wr_answer: assert property (wr_take ##0 awaddr != OFF_TXDATA |->
      ##2 bvalid) else $error("write unanswered");
   a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_rd_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read unanswered");
   a_r_hold: assert property (rvalid && !rready |=> rvalid)
      else $error("read data dropped");
   a_aw_closed: assert property (wr_take |=> !awready && !wready)
      else $error("second write taken");
   a_unmapped_err: assert property (bad_wr |-> ##2 bresp == RESP_SLVERR)
      else $error("unmapped write accepted");
   a_mapped_ok: assert property (wr_take ##0 awaddr < 8'h14 |->
      ##2 bresp == RESP_OKAY) else $error("mapped write refused");
   a_rst_idle: assert property ($rose(aresetn) |->
      &peripheral_select_lines_n && !bvalid && !rvalid)
      else $error("outputs busy after reset");
endmodule

// ==== spq_target.sv ====
// behavioural target on select zero answering a fixed byte
`timescale 1ns/1ps
module spq_target (
   // clock
   input wire logic aclk,
   // serial link
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic mosi,
   output logic miso
);
   logic [7:0] rx_r = 8'h00, tx_r = 8'h3c;
   logic last_r = 1'h0, junk_r = 1'h0, sel_r = 1'h1;
   int edges = 0;
   // churns while deselected so no stale bit reads as valid
   assign miso = sel_n ? junk_r : tx_r[7];
   always @(posedge aclk) begin
      junk_r <= ~junk_r;
      last_r <= sclk;
      sel_r <= sel_n;
      // the last clock edge and the release share one edge
      if (sel_n && sel_r) tx_r <= 8'h3c;
      else if (sclk != last_r) begin
         edges <= edges + 1;
         if (sclk) rx_r <= {rx_r[6:0], mosi};
         else tx_r <= {tx_r[6:0], 1'h0};
      end
   end
endmodule

// ==== spq_port_tb.sv ====
// self-checking bench of the serial peripheral port
`timescale 1ns/1ps
bind spq_port spq_port_chk u_chk (.*);
module spq_port_tb import spq_pkg::*;;
   localparam logic [31:0] CFGS [5] = '{32'h202, 32'h112, 32'h122,
      32'h301, 32'h101};
   localparam logic [31:0] PULSES [5] = '{32'h8, 32'ha, 32'ha, 32'h9, 32'h8};
   logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
   logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic tgt_sclk_i = 1'h0, tgt_sel_n_i = 1'h1, tgt_mosi_i = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, miso_i, mosi_o;
   logic serial_clock_pin, dma_tx_req, dma_half;
   logic [1:0] bresp, rresp, br, rr;
   logic [NUM_SEL-1:0] peripheral_select_lines_n;
   int n_mismatch = 0, checks = 0, cyc = 0;
   spq_port DUT (.*);
   spq_target tgt (.aclk, .sclk(serial_clock_pin),
      .sel_n(peripheral_select_lines_n[0]), .mosi(mosi_o), .miso(miso_i));
   always #5 aclk = ~aclk;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t %h %h", $time, s, e);
      end
   endtask
   task final_report;
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc > 8000) begin
         n_mismatch++;
         final_report;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h1;
      @(posedge aclk);
      br = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h1;
      @(posedge aclk);
      d = rdata;
      rr = rresp;
      rready <= 1'h0;
   endtask
   initial begin
      logic [31:0] v;
      int e0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      rd(OFF_SEL0, v);
      chk(v, CFG_RST);
      rd(8'h40, v);
      chk(rr, RESP_SLVERR);
      wr(8'h40, 32'h1);
      chk(br, RESP_SLVERR);
      // ten-bit select zero, byte-wide select one in use
      wr(OFF_SEL0, 32'h120);
      wr(OFF_MODE, 32'h10001);
      rd(OFF_STATUS, v);
      chk({dma_half, v[ST_DMA_HALF]}, 2'h3);
      wr(OFF_MODE, 32'h0);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_CTRL, 32'h2);
      rd(OFF_STATUS, v);
      chk(v[ST_ENABLED], 1'h1);
      wr(OFF_CTRL, 32'h80);
      wr(OFF_CTRL, 32'h80);
      wr(OFF_CTRL, 32'h1);
      rd(OFF_STATUS, v);
      chk({v[ST_ENABLED], v[ST_TX_SPACE], dma_tx_req}, 3'h4);
      wr(OFF_MODE, 32'h1);
      wr(OFF_CTRL, 32'h2);
      wr(OFF_CTRL, 32'h1);
      rd(OFF_STATUS, v);
      chk({dma_tx_req, v[ST_TX_SPACE]}, 2'h3);
      for (int k = 0; k < 5; k++) begin
         wr(OFF_SEL0, CFGS[k]);
         e0 = tgt.edges;
         wr(OFF_TXDATA, 32'h10000a5);
         v = 32'h0;
         for (int i = 0; i < 99 && !v[ST_RX_READY]; i++) rd(OFF_STATUS, v);
         rd(OFF_RXDATA, v);
         for (int i = 0; i < 99 && !peripheral_select_lines_n[0]; i++)
            @(posedge aclk);
         chk((tgt.edges - e0) / 2, PULSES[k]);
         if (k == 0) chk({v[15:0], tgt.rx_r}, 24'h3ca5);
      end
      final_report;
   end
endmodule
